// ---- shared/pts_pkg.sv ----
package pts_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // byte addresses of the register words
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ = 8'h0c;

  // control register layout
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_W = 2;
  localparam int ON_BIT = 2;
  localparam int POSTSCALE_LSB = 3;
  localparam int POSTSCALE_W = 4;
  localparam logic [REG_W-1:0] CTRL_MASK = 8'h7f;

  // interrupt register layout
  localparam int FLAG_BIT = 0;
  localparam int EN_BIT = 1;

  // reset values
  localparam logic [REG_W-1:0] CTRL_RST = 8'h00;
  localparam logic [REG_W-1:0] COUNT_RST = 8'h00;
  localparam logic [REG_W-1:0] PERIOD_RST = 8'hff;

  // oscillator to instruction clock: one tick every four aclk cycles
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;

  // prescaler terminal counts for divide by 1, 4, 16 and 64
  localparam int PRE_W = 6;
  localparam logic [PRE_W-1:0] PRE_LIM_1 = 6'h00;
  localparam logic [PRE_W-1:0] PRE_LIM_4 = 6'h03;
  localparam logic [PRE_W-1:0] PRE_LIM_16 = 6'h0f;
  localparam logic [PRE_W-1:0] PRE_LIM_64 = 6'h3f;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    PTS_WS_IDLE = 2'b01,
    PTS_WS_RESP = 2'b10
  } pts_wstate_e;

  typedef enum logic [1:0] {
    PTS_RS_IDLE = 2'b01,
    PTS_RS_DATA = 2'b10
  } pts_rstate_e;
endpackage

// ---- shared/pts_scale_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pts_scale_if;
  import pts_pkg::*;
  logic instr_tick;
  logic clear;
  logic on;
  logic [PRESCALE_W-1:0] prescale_select;
  logic [POSTSCALE_W-1:0] postscale_select;
  logic match;
  logic pre_tick;
  logic post_tick;

  modport ctrl (
    output instr_tick,
    output clear,
    output on,
    output prescale_select,
    output postscale_select,
    output match,
    input pre_tick,
    input post_tick
  );

  modport scaler (
    input instr_tick,
    input clear,
    input on,
    input prescale_select,
    input postscale_select,
    input match,
    output pre_tick,
    output post_tick
  );
endinterface
`default_nettype wire

// ---- rtl/pts_scaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module pts_scaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  pts_scale_if.scaler sif
);
  import pts_pkg::*;

  logic [PRE_W-1:0] pre_cnt_r;
  logic [POSTSCALE_W-1:0] post_cnt_r;
  logic [PRE_W-1:0] pre_lim;

  always_comb begin
    case (sif.prescale_select)
      2'h0: pre_lim = PRE_LIM_1;
      2'h1: pre_lim = PRE_LIM_4;
      2'h2: pre_lim = PRE_LIM_16;
      default: pre_lim = PRE_LIM_64;
    endcase
  end

  // a clearing write swallows the tick so the count cannot move that cycle
  assign sif.pre_tick = ce & sif.instr_tick & sif.on & ~sif.clear & (pre_cnt_r == pre_lim);
  assign sif.post_tick = ce & sif.match & ~sif.clear & (post_cnt_r == sif.postscale_select);

  // (R06) scaler clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_r <= '0;
    end else if (ce) begin
      if (sif.clear) begin
        pre_cnt_r <= '0;
      end else if (sif.instr_tick && sif.on) begin
        // (R03) divide ratio select
        pre_cnt_r <= (pre_cnt_r == pre_lim) ? '0 : PRE_W'(pre_cnt_r + 6'h01);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      post_cnt_r <= '0;
    end else if (ce) begin
      if (sif.clear) begin
        post_cnt_r <= '0;
      end else if (sif.match) begin
        // (R09) n plus one matches
        post_cnt_r <= (post_cnt_r == sif.postscale_select) ? '0 : POSTSCALE_W'(post_cnt_r + 4'h1);
      end
    end
  end

  a_scaler_clear: assert property (@(posedge aclk) disable iff (!aresetn) // (R06)
    (ce && sif.clear) |=> (pre_cnt_r == '0) && (post_cnt_r == '0))
    else $error("scaler counters not cleared");

  a_post_ratio: assert property (@(posedge aclk) disable iff (!aresetn) // (R09)
    (ce && sif.match && !sif.clear && sif.postscale_select == 4'h0) |-> sif.post_tick)
    else $error("postscaler missed a match at ratio 1:1");
endmodule
`default_nettype wire

// ---- rtl/pts_top.sv ----
// Notes on behaviour
// (R01) count clock is the instruction clock, aclk divided by four
// (R02) count starts at zero, steps by one per prescaled tick while on
// (R03) prescale field: 00 div 1, 01 div 4, 10 div 16, 11 div 64
// (R04) count equal to period gives a match pulse and reloads zero
// (R05) reset clears count and sets period to all ones
// (R06) count write, control write and reset clear both scaler counters
// (R07) control write leaves the count value as it was
// (R08) match pulses clock the postscaler, which sets the interrupt flag
// (R09) postscale field n sets the flag every n+1 matches
// (R10) interrupt request needs the enable bit; flag latches regardless
// (R11) unscaled match drives the pwm time base and optional serial shift clock
// (R12) in sleep the count and period hold, counting resumes after wake
// (R13) count and period readable and writable at any time
// (R14) on bit gates counting; when clear the count holds
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pts_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sleep,
  input wire logic ssp_shift_sel,
  input wire logic [pts_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pts_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pts_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [pts_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic pwm_timebase,
  output logic ssp_shift_clk,
  output logic timer_irq
);
  import pts_pkg::*;

  pts_scale_if sif ();

  pts_wstate_e ws_r;
  pts_rstate_e rs_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic aw_got_r;
  logic [REG_W-1:0] w_data_r;
  logic w_lane_r;
  logic w_got_r;
  logic [1:0] bresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;

  logic [REG_W-1:0] ctrl_r;
  logic [REG_W-1:0] count_r;
  logic [REG_W-1:0] period_r;
  logic flag_r;
  logic irq_en_r;
  logic irq_r;
  logic pwm_r;
  logic ssp_r;
  logic [PHASE_W-1:0] phase_r;

  logic wr_fire;
  logic wr_hit;
  logic ctrl_wr;
  logic count_wr;
  logic period_wr;
  logic irq_wr;
  logic instr_tick;
  logic match_hit;
  logic rd_hit;
  logic [REG_W-1:0] rd_val;

  // the unused protection bits carry no meaning for this block
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot, wdata[DATA_W-1:REG_W], wstrb[3:1]};

  // write channel: address and data are taken independently, then applied together
  assign awready = (ws_r == PTS_WS_IDLE) & ~aw_got_r;
  assign wready = (ws_r == PTS_WS_IDLE) & ~w_got_r;
  assign bvalid = (ws_r == PTS_WS_RESP);
  assign bresp = bresp_r;
  assign wr_fire = ce & (ws_r == PTS_WS_IDLE) & aw_got_r & w_got_r;

  always_comb begin
    case (aw_addr_r)
      ADDR_CTRL,
      ADDR_COUNT,
      ADDR_PERIOD,
      ADDR_IRQ: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // only byte lane 0 carries register bits, so a write with it off changes nothing
  assign ctrl_wr = wr_fire & w_lane_r & (aw_addr_r == ADDR_CTRL);
  assign count_wr = wr_fire & w_lane_r & (aw_addr_r == ADDR_COUNT);
  assign period_wr = wr_fire & w_lane_r & (aw_addr_r == ADDR_PERIOD);
  assign irq_wr = wr_fire & w_lane_r & (aw_addr_r == ADDR_IRQ);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (wr_fire) begin
        aw_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r <= 1'b0;
      w_data_r <= '0;
      w_lane_r <= 1'b0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        w_data_r <= wdata[REG_W-1:0];
        w_lane_r <= wstrb[0];
      end else if (wr_fire) begin
        w_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_r <= PTS_WS_IDLE;
      bresp_r <= RESP_OKAY;
    end else if (ce) begin
      case (ws_r)
        PTS_WS_IDLE: begin
          if (wr_fire) begin
            ws_r <= PTS_WS_RESP;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_DECERR;
          end
        end
        PTS_WS_RESP: begin
          if (bready) begin
            ws_r <= PTS_WS_IDLE;
          end
        end
        default: ws_r <= PTS_WS_IDLE;
      endcase
    end
  end

  // read channel: data registered on the address handshake
  assign arready = (rs_r == PTS_RS_IDLE);
  assign rvalid = (rs_r == PTS_RS_DATA);
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // (R13) count and period readback
  always_comb begin
    rd_hit = 1'b1;
    case (araddr)
      ADDR_CTRL: rd_val = ctrl_r;
      ADDR_COUNT: rd_val = count_r;
      ADDR_PERIOD: rd_val = period_r;
      ADDR_IRQ: rd_val = REG_W'({irq_en_r, flag_r});
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs_r <= PTS_RS_IDLE;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      case (rs_r)
        PTS_RS_IDLE: begin
          if (arvalid) begin
            rs_r <= PTS_RS_DATA;
            rdata_r <= DATA_W'(rd_val);
            rresp_r <= rd_hit ? RESP_OKAY : RESP_DECERR;
          end
        end
        PTS_RS_DATA: begin
          if (rready) begin
            rs_r <= PTS_RS_IDLE;
          end
        end
        default: rs_r <= PTS_RS_IDLE;
      endcase
    end
  end

  // control register; bit 7 is unimplemented and reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
    end else if (ce && ctrl_wr) begin
      ctrl_r <= w_data_r & CTRL_MASK;
    end
  end

  // (R01) instruction clock from aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= '0;
    end else if (ce && !sleep) begin
      phase_r <= PHASE_W'(phase_r + 2'h1);
    end
  end

  // (R12) sleep stops the time base
  assign instr_tick = ce & ~sleep & (phase_r == PHASE_LAST);

  // (R06) clears on writes
  assign sif.clear = ctrl_wr | count_wr;
  assign sif.instr_tick = instr_tick;
  // (R14) on bit gates prescaler
  assign sif.on = ctrl_r[ON_BIT];
  assign sif.prescale_select = ctrl_r[PRESCALE_LSB +: PRESCALE_W];
  assign sif.postscale_select = ctrl_r[POSTSCALE_LSB +: POSTSCALE_W];

  // (R04) compare count with period
  assign match_hit = sif.pre_tick & (count_r == period_r);
  // (R08) match clocks postscaler
  assign sif.match = match_hit;

  pts_scaler u_scaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sif(sif.scaler)
  );

  // (R02) count advance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= COUNT_RST;
    end else if (ce) begin
      // (R07) only count writes load
      if (count_wr) begin
        count_r <= w_data_r;
      end else if (match_hit) begin
        count_r <= COUNT_RST;
      end else if (sif.pre_tick) begin
        count_r <= REG_W'(count_r + 8'h01);
      end
    end
  end

  // (R05) period resets to all ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_r <= PERIOD_RST;
    end else if (ce && period_wr) begin
      period_r <= w_data_r;
    end
  end

  // (R11) unscaled match outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_r <= 1'b0;
      ssp_r <= 1'b0;
    end else if (ce) begin
      pwm_r <= match_hit;
      ssp_r <= match_hit & ssp_shift_sel;
    end
  end

  assign pwm_timebase = pwm_r;
  assign ssp_shift_clk = ssp_r;

  // (R08) flag set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      if (sif.post_tick) begin
        flag_r <= 1'b1;
      end else if (irq_wr && w_data_r[FLAG_BIT]) begin
        flag_r <= 1'b0;
      end
    end
  end

  // (R10) enable gates request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce) begin
      if (irq_wr) begin
        irq_en_r <= w_data_r[EN_BIT];
      end
      irq_r <= flag_r & irq_en_r;
    end
  end

  assign timer_irq = irq_r;

  a_instr_rate: assert property (@(posedge aclk) disable iff (!aresetn) // (R01)
    instr_tick |=> !instr_tick [*3])
    else $error("instruction tick more often than every fourth cycle");

  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn) // (R02)
    (sif.pre_tick && !count_wr && count_r != period_r) |=> count_r == REG_W'($past(count_r) + 8'h01))
    else $error("count did not step by one");

  a_count_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // (R04)
    (match_hit && !count_wr) |=> (count_r == COUNT_RST) && pwm_timebase)
    else $error("match did not reload zero and pulse");

  a_reset_values: assert property (@(posedge aclk) disable iff (!aresetn) // (R05)
    $rose(aresetn) |-> (count_r == COUNT_RST) && (period_r == PERIOD_RST))
    else $error("wrong count or period after reset");

  a_ctrl_keeps_count: assert property (@(posedge aclk) disable iff (!aresetn) // (R07)
    ctrl_wr |=> count_r == $past(count_r))
    else $error("control write changed the count");

  a_flag_latch: assert property (@(posedge aclk) disable iff (!aresetn) // (R08)
    sif.post_tick |=> flag_r ##1 (timer_irq == $past(irq_en_r)))
    else $error("postscaler event not latched into the flag");

  a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn) // (R10)
    (ce && !irq_en_r) |=> !timer_irq)
    else $error("interrupt raised while disabled");

  a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn) // (R12)
    (sleep && !count_wr && !period_wr) |=> $stable(count_r) && $stable(period_r))
    else $error("timer moved during sleep");

  a_count_read: assert property (@(posedge aclk) disable iff (!aresetn) // (R13)
    (ce && arvalid && arready && araddr == ADDR_COUNT) |=> rvalid && rdata == DATA_W'($past(count_r)))
    else $error("count read returned a wrong value");

  a_off_hold: assert property (@(posedge aclk) disable iff (!aresetn) // (R14)
    (!ctrl_r[ON_BIT] && !count_wr) |=> $stable(count_r))
    else $error("count moved while the timer is off");
endmodule
`default_nettype wire

// ---- testbench/tb_period_timer_with_scalers.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_period_timer_with_scalers;
  import pts_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic sleep = 1'b0;
  logic ssp_shift_sel = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pwm_timebase, ssp_shift_clk, timer_irq;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rsp;
  logic [DATA_W-1:0] rd;
  int fails = 0;
  int checks = 0;
  int cyc = 0;

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // ce and prot are tied: ce gating is not a documented behaviour
  pts_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .sleep(sleep), .ssp_shift_sel(ssp_shift_sel),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pwm_timebase(pwm_timebase), .ssp_shift_clk(ssp_shift_clk), .timer_irq(timer_irq));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered just after a rising edge; address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    logic a_d;
    logic w_d;
    n = 0;
    a_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a_d && w_d) && n < 100) begin
      @(posedge aclk);
      n++;
      if (!a_d && awready === 1'b1) begin
        a_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready === 1'b1) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
      // raised only after the taking edge, so back to back calls never drive it twice in one step
      if (a_d && w_d) bready <= 1'b1;
    end
    while (bvalid !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    chk("write answer", 32'h1, {31'h0, bvalid === 1'b1});
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    rready <= 1'b1;
    while (rvalid !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    chk("read answer", 32'h1, {31'h0, rvalid === 1'b1});
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wv(input logic [7:0] a, input logic [7:0] d);
    wr(a, {24'h0, d}, 4'hf, rsp);
    chk("write response", {30'h0, RESP_OKAY}, {30'h0, rsp});
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    rdr(a, rd, rsp);
    chk(what, {24'h0, exp}, rd);
    chk("read response", {30'h0, RESP_OKAY}, {30'h0, rsp});
  endtask

  task automatic wait_pulse(output int t);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (pwm_timebase !== 1'b1 && n < 2000);
    t = cyc;
    chk("serial shift clock", {31'h0, ssp_shift_sel}, {31'h0, ssp_shift_clk});
  endtask

  task automatic t_reset();
    rchk("control reset", ADDR_CTRL, CTRL_RST);
    rchk("count reset", ADDR_COUNT, COUNT_RST);
    rchk("period reset", ADDR_PERIOD, PERIOD_RST);
    rchk("interrupt reset", ADDR_IRQ, 8'h00);
  endtask

  task automatic t_regs();
    wv(ADDR_COUNT, 8'h5a);
    wv(ADDR_CTRL, 8'h7b);
    rchk("count after control write", ADDR_COUNT, 8'h5a);
    rchk("control readback", ADDR_CTRL, 8'h7b);
    wv(ADDR_CTRL, 8'hff);
    rchk("control unused bit", ADDR_CTRL, 8'h7f);
    wv(ADDR_PERIOD, 8'h33);
    rchk("period readback", ADDR_PERIOD, 8'h33);
    wr(ADDR_PERIOD, 32'h44, 4'h0, rsp);
    rchk("period after strobeless write", ADDR_PERIOD, 8'h33);
    wr(8'h10, 32'h55, 4'hf, rsp);
    chk("unmapped write response", {30'h0, RESP_DECERR}, {30'h0, rsp});
    rdr(8'h10, rd, rsp);
    chk("unmapped read data", 32'h0, rd);
    chk("unmapped read response", {30'h0, RESP_DECERR}, {30'h0, rsp});
    wv(ADDR_CTRL, 8'h00);
  endtask

  // match spacing: (period+1) prescaled ticks of four aclk times the divide
  task automatic t_rate();
    int t1;
    int t2;
    for (int c = 0; c < 4; c++) begin
      wv(ADDR_CTRL, 8'h00);
      wv(ADDR_COUNT, 8'h00);
      wv(ADDR_PERIOD, 8'h02);
      ssp_shift_sel <= c[0];
      wv(ADDR_CTRL, 8'h04 | 8'(c));
      wait_pulse(t1);
      wait_pulse(t2);
      chk("match spacing", 32'(3 * 4 * (1 << (2 * c))), 32'(t2 - t1));
    end
    ssp_shift_sel <= 1'b0;
  endtask

  task automatic t_post();
    int p;
    int n;
    logic [3:0] sel [3] = '{4'h0, 4'h2, 4'hf};
    foreach (sel[i]) begin
      wv(ADDR_CTRL, 8'h00);
      wv(ADDR_PERIOD, 8'h00);
      wv(ADDR_COUNT, 8'h00);
      wv(ADDR_IRQ, 8'h03);
      wv(ADDR_CTRL, {1'b0, sel[i], 3'h4});
      p = 0;
      n = 0;
      while (timer_irq !== 1'b1 && n < 1000) begin
        @(posedge aclk);
        n++;
        if (pwm_timebase === 1'b1) p++;
      end
      chk("matches per flag", 32'(sel[i]) + 32'h1, 32'(p));
    end
    wv(ADDR_CTRL, 8'h00);
    wv(ADDR_IRQ, 8'h01);
    wv(ADDR_CTRL, 8'h04);
    repeat (40) @(posedge aclk);
    chk("request while disabled", 32'h0, {31'h0, timer_irq});
    rchk("flag while disabled", ADDR_IRQ, 8'h01);
    wv(ADDR_CTRL, 8'h00);
    wv(ADDR_IRQ, 8'h02);
    repeat (2) @(posedge aclk);
    chk("request once enabled", 32'h1, {31'h0, timer_irq});
    wv(ADDR_IRQ, 8'h01);
  endtask

  task automatic t_sleep();
    wv(ADDR_PERIOD, 8'hff);
    wv(ADDR_COUNT, 8'h10);
    repeat (40) @(posedge aclk);
    rchk("count while off", ADDR_COUNT, 8'h10);
    sleep <= 1'b1;
    wv(ADDR_CTRL, 8'h04);
    repeat (40) @(posedge aclk);
    rchk("count in sleep", ADDR_COUNT, 8'h10);
    rchk("period in sleep", ADDR_PERIOD, 8'hff);
    sleep <= 1'b0;
    repeat (40) @(posedge aclk);
    rdr(ADDR_COUNT, rd, rsp);
    chk("count resumes", 32'h1, {31'h0, rd > 32'h10 && rd < 32'h30});
  endtask

  // a second reset in mid-run must restore every register, whatever was written before
  task automatic t_rerun();
    wv(ADDR_PERIOD, 8'h21);
    wv(ADDR_IRQ, 8'h02);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
  endtask

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_rate();
    t_post();
    t_sleep();
    t_rerun();
    wrap_up();
  end

  // the run needs roughly 2500 cycles
  initial begin
    repeat (40000) @(posedge aclk);
    fails++;
    $display("mismatch watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule
`default_nettype wire
